// File: gpiw_params.svh
// Register offsets, reset values and fixed numbers of the pin interrupt and wake block
`ifndef GPIW_PARAMS_SVH
`define GPIW_PARAMS_SVH
`define GPIW_OFS_CFG_SEL0      8'h00
`define GPIW_OFS_CFG_SEL0_CLR  8'h08
`define GPIW_OFS_OUT_EN        8'h0C
`define GPIW_OFS_OUT_EN_SET    8'h10
`define GPIW_OFS_OUT_EN_CLR    8'h14
`define GPIW_OFS_OUT_VAL       8'h18
`define GPIW_OFS_OUT_VAL_CLR   8'h20
`define GPIW_OFS_IN_VAL        8'h24
`define GPIW_OFS_TRIG_TYPE     8'h28
`define GPIW_OFS_TRIG_POL      8'h2C
`define GPIW_OFS_IRQ_EN        8'h34
`define GPIW_OFS_IRQ_EN_SET    8'h38
`define GPIW_OFS_IRQ_EN_CLR    8'h3C
`define GPIW_OFS_IRQ_FLAGS     8'h40
`define GPIW_OFS_IRQ_FLAG_CLR  8'h48
`define GPIW_OFS_BOTH_EDGES    8'h5C
`define GPIW_OFS_IN_EN         8'h84
`define GPIW_OFS_WAKE_EN       8'h90
`define GPIW_OFS_WAKE_STAT     8'h94
`define GPIW_OFS_PM_WAKE_SRC   8'h98
`define GPIW_RST_CFG_SEL0      32'hFFFFFFFF
`define GPIW_RST_ZERO          32'h00000000
`define GPIW_RST_PM_SRC        1'b0
`define GPIW_PORT_IRQ_VECTOR   8'h28
`define GPIW_WAKE_IRQ_VECTOR   8'h46
`endif

// File: gpiw_pin_env.sv
// Pin-side model: external pin levels that move between clock edges
`default_nettype none
module gpiw_pin_env (
   input  wire logic [31:0] pin_req,  // Level asked by the bench
   output logic      [31:0] pin_lvl   // Level seen at the pads
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin_lvl = 32'h00000000;
   // Pads settle 7 ns after the request, away from the clock edge
   always @(pin_req) pin_lvl <= #7 pin_req;
endmodule
`default_nettype wire

// File: gpiw_pkg.sv
// Types shared by the pin interrupt and wake block
`default_nettype none
package gpiw_pkg;
   typedef logic [31:0] gpiw_word_t;
   typedef enum logic [1:0] {
      GPIW_BUS_IDLE,
      GPIW_BUS_WRITE,
      GPIW_BUS_READ
   } gpiw_bus_t;
endpackage
`default_nettype wire

// File: gpiw_port.sv
// Pin interrupt detection and wake logic of a 32-bit port with an AHB-Lite register slave
//
// Functional notes
// RULE_01: Pin events arise only in I/O mode with input enabled.
// RULE_02: Pins in alternate function leave interrupts to their peripheral.
// RULE_03: Per-pin enables; all pins share one port interrupt request.
// RULE_04: Clearing input enable stops new triggers; latched flags stay pending.
// RULE_05: Writing 1 to a flag-clear bit clears that pin's flag.
// RULE_06: Trigger type 0 is level, 1 is edge.
// RULE_07: Level mode: polarity 1 triggers high, 0 triggers low.
// RULE_08: Edge mode: polarity 0 rising, 1 falling.
// RULE_09: Edge mode with both-edges bit set triggers on either edge.
// RULE_10: Interrupt enable lets a pin's events raise the port request.
// RULE_11: Status shows one flag per pin; several may be set.
// RULE_12: Handler clears every set flag by writing ones before return.
// RULE_13: Port request is interrupt vector 40 for pins 31 to 0.
// RULE_14: Port interrupts serve active and sleep and wake sleep modes.
// RULE_15: Separate wake path on pin edges for deep low-power modes.
// RULE_16: Wake path detects edges only, never levels.
// RULE_17: All pins share one wake request, vector 70.
// RULE_18: Per-pin wake enable; pin joins wake detection only when set.
// RULE_19: Pin wake acts only when power manager source enable is 1.
// RULE_20: A waking pin sets its bit in wake status.
// RULE_21: Writing all ones to wake status clears every wake flag.
// RULE_22: All interrupt and wake fields return to reset value on reset.
// RULE_23: Pins are synchronised; edges come from successive synced samples.
//
// Register access over AHB-Lite is this design's own decision.
`include "gpiw_params.svh"
`default_nettype none
module gpiw_port (
   input  wire logic        hclk,        // System clock
   input  wire logic        hresetn,     // Async reset, active low
   input  wire logic        hsel,        // Slave select
   input  wire logic [31:0] haddr,       // Byte address
   input  wire logic [1:0]  htrans,      // Transfer type
   input  wire logic        hwrite,      // Write when high
   input  wire logic [2:0]  hsize,       // Transfer size
   input  wire logic [31:0] hwdata,      // Write data
   input  wire logic        hready,      // Bus ready
   output logic      [31:0] hrdata,      // Read data
   output logic             hreadyout,   // Slave ready
   output logic             hresp,       // Always OKAY
   input  wire logic [31:0] pin_in,      // Pin levels
   output logic      [31:0] pin_out,     // Pin output values
   output logic      [31:0] pin_oe,      // Pin output enables
   output logic             port_irq,    // Port interrupt request
   output logic             wake_irq     // Wake interrupt request
);
   gpiw_pkg::gpiw_bus_t  bus_state;
   logic [7:0]           bus_addr;
   gpiw_pkg::gpiw_word_t cfg_sel0;
   gpiw_pkg::gpiw_word_t trig_type;
   gpiw_pkg::gpiw_word_t trig_pol;
   gpiw_pkg::gpiw_word_t both_edges;
   gpiw_pkg::gpiw_word_t irq_en;
   gpiw_pkg::gpiw_word_t irq_flags;
   gpiw_pkg::gpiw_word_t in_en;
   gpiw_pkg::gpiw_word_t wake_en;
   gpiw_pkg::gpiw_word_t wake_stat;
   logic                 pm_wake_src;
   logic [31:0]          in_meta;
   logic [31:0]          in_sync;
   logic [31:0]          in_prev;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Address phase taken when selected, the bus is ready and the transfer is NONSEQ or SEQ (htrans[1] set)
   wire         take       = hsel & hready & htrans[1];
   wire         wr_phase   = (bus_state == gpiw_pkg::GPIW_BUS_WRITE);
   wire         wr_cfg     = wr_phase & hit(bus_addr, `GPIW_OFS_CFG_SEL0);
   wire         wr_cfg_clr = wr_phase & hit(bus_addr, `GPIW_OFS_CFG_SEL0_CLR);
   wire         wr_oe      = wr_phase & hit(bus_addr, `GPIW_OFS_OUT_EN);
   wire         wr_oe_set  = wr_phase & hit(bus_addr, `GPIW_OFS_OUT_EN_SET);
   wire         wr_oe_clr  = wr_phase & hit(bus_addr, `GPIW_OFS_OUT_EN_CLR);
   wire         wr_out     = wr_phase & hit(bus_addr, `GPIW_OFS_OUT_VAL);
   wire         wr_out_clr = wr_phase & hit(bus_addr, `GPIW_OFS_OUT_VAL_CLR);
   wire         wr_type    = wr_phase & hit(bus_addr, `GPIW_OFS_TRIG_TYPE);
   wire         wr_pol     = wr_phase & hit(bus_addr, `GPIW_OFS_TRIG_POL);
   wire         wr_ien     = wr_phase & hit(bus_addr, `GPIW_OFS_IRQ_EN);
   wire         wr_ien_set = wr_phase & hit(bus_addr, `GPIW_OFS_IRQ_EN_SET);
   wire         wr_ien_clr = wr_phase & hit(bus_addr, `GPIW_OFS_IRQ_EN_CLR);
   wire         wr_fl_clr  = wr_phase & hit(bus_addr, `GPIW_OFS_IRQ_FLAG_CLR);
   wire         wr_dual    = wr_phase & hit(bus_addr, `GPIW_OFS_BOTH_EDGES);
   wire         wr_inen    = wr_phase & hit(bus_addr, `GPIW_OFS_IN_EN);
   wire         wr_wen     = wr_phase & hit(bus_addr, `GPIW_OFS_WAKE_EN);
   wire         wr_wstat   = wr_phase & hit(bus_addr, `GPIW_OFS_WAKE_STAT);
   wire         wr_pm      = wr_phase & hit(bus_addr, `GPIW_OFS_PM_WAKE_SRC);

   // RULE_23 edge source
   wire  [31:0] rise = in_sync & ~in_prev;
   wire  [31:0] fall = ~in_sync & in_prev;
   // RULE_01 RULE_02 pin gating
   wire  [31:0] armed = cfg_sel0 & in_en;
   // RULE_06 RULE_07 level match
   wire  [31:0] lvl_hit = ~(in_sync ^ trig_pol);
   // RULE_08 RULE_09 edge select
   wire  [31:0] edge_hit = (rise & ~trig_pol) | (fall & trig_pol) | ((rise | fall) & both_edges);
   // RULE_04 RULE_06 event
   wire  [31:0] irq_set = armed & ((trig_type & edge_hit) | (~trig_type & lvl_hit));
   // RULE_05 RULE_11 set wins over clear
   wire  [31:0] flag_clr = wr_fl_clr ? hwdata : 32'h00000000;
   wire  [31:0] next_irq_flags = (irq_flags & ~flag_clr) | irq_set;
   // RULE_15 RULE_16 RULE_18 RULE_19 edge-only wake
   wire  [31:0] wake_set = (rise | fall) & wake_en & {32{pm_wake_src}};
   // RULE_20 RULE_21 wake status
   wire  [31:0] wake_clr = wr_wstat ? hwdata : 32'h00000000;
   wire  [31:0] next_wake_stat = (wake_stat & ~wake_clr) | wake_set;
   wire  [31:0] next_cfg_sel0 = wr_cfg ? hwdata : (wr_cfg_clr ? (cfg_sel0 & ~hwdata) : cfg_sel0);
   wire  [31:0] next_oe = wr_oe ? hwdata :
                          wr_oe_set ? (pin_oe | hwdata) :
                          wr_oe_clr ? (pin_oe & ~hwdata) : pin_oe;
   wire  [31:0] next_out = wr_out ? hwdata : (wr_out_clr ? (pin_out & ~hwdata) : pin_out);
   wire  [31:0] next_irq_en = wr_ien ? hwdata :
                              wr_ien_set ? (irq_en | hwdata) :
                              wr_ien_clr ? (irq_en & ~hwdata) : irq_en;

   // Read mux, evaluated in the wait cycle so earlier writes are visible
   wire  [31:0] rd_mux =
      hit(bus_addr, `GPIW_OFS_CFG_SEL0)    ? cfg_sel0   :
      hit(bus_addr, `GPIW_OFS_OUT_EN)      ? pin_oe     :
      hit(bus_addr, `GPIW_OFS_OUT_VAL)     ? pin_out    :
      hit(bus_addr, `GPIW_OFS_IN_VAL)      ? (in_sync & in_en) :
      hit(bus_addr, `GPIW_OFS_TRIG_TYPE)   ? trig_type  :
      hit(bus_addr, `GPIW_OFS_TRIG_POL)    ? trig_pol   :
      hit(bus_addr, `GPIW_OFS_IRQ_EN)      ? irq_en     :
      hit(bus_addr, `GPIW_OFS_IRQ_FLAGS)   ? irq_flags  :
      hit(bus_addr, `GPIW_OFS_BOTH_EDGES)  ? both_edges :
      hit(bus_addr, `GPIW_OFS_IN_EN)       ? in_en      :
      hit(bus_addr, `GPIW_OFS_WAKE_EN)     ? wake_en    :
      hit(bus_addr, `GPIW_OFS_WAKE_STAT)   ? wake_stat  :
      hit(bus_addr, `GPIW_OFS_PM_WAKE_SRC) ? {31'h00000000, pm_wake_src} : 32'h00000000;

   wire         rd_wait = (bus_state == gpiw_pkg::GPIW_BUS_READ) & ~hreadyout;

   // Bus phase tracking; reads take one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= gpiw_pkg::GPIW_BUS_IDLE;
         bus_addr  <= 8'h00;
         hreadyout <= 1'b1;
         hrdata    <= 32'h00000000;
      end else if (rd_wait) begin
         hrdata    <= rd_mux;
         hreadyout <= 1'b1;
      end else if (take) begin
         bus_state <= hwrite ? gpiw_pkg::GPIW_BUS_WRITE : gpiw_pkg::GPIW_BUS_READ;
         bus_addr  <= haddr[7:0];
         hreadyout <= hwrite;
      end else begin
         bus_state <= gpiw_pkg::GPIW_BUS_IDLE;
      end
   end

   // Response is always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // RULE_23 two-stage synchroniser and history
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_meta <= 32'h00000000;
         in_sync <= 32'h00000000;
         in_prev <= 32'h00000000;
      end else begin
         in_meta <= pin_in;
         in_sync <= in_meta;
         in_prev <= in_sync;
      end
   end

   // Register write values
   wire  [31:0] next_trig_type   = wr_type ? hwdata : trig_type;
   wire  [31:0] next_trig_pol    = wr_pol ? hwdata : trig_pol;
   wire  [31:0] next_both_edges  = wr_dual ? hwdata : both_edges;
   wire  [31:0] next_in_en       = wr_inen ? hwdata : in_en;
   wire  [31:0] next_wake_en     = wr_wen ? hwdata : wake_en;
   wire         next_pm_wake_src = wr_pm ? hwdata[0] : pm_wake_src;

   // RULE_22 pin mode select
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_sel0 <= `GPIW_RST_CFG_SEL0;
      end else begin
         cfg_sel0 <= next_cfg_sel0;
      end
   end

   // Output enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_oe <= `GPIW_RST_ZERO;
      end else begin
         pin_oe <= next_oe;
      end
   end

   // Output values
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= `GPIW_RST_ZERO;
      end else begin
         pin_out <= next_out;
      end
   end

   // RULE_06 trigger type
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_type <= `GPIW_RST_ZERO;
      end else begin
         trig_type <= next_trig_type;
      end
   end

   // RULE_07 RULE_08 trigger polarity
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_pol <= `GPIW_RST_ZERO;
      end else begin
         trig_pol <= next_trig_pol;
      end
   end

   // RULE_09 both edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         both_edges <= `GPIW_RST_ZERO;
      end else begin
         both_edges <= next_both_edges;
      end
   end

   // RULE_10 interrupt enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_en <= `GPIW_RST_ZERO;
      end else begin
         irq_en <= next_irq_en;
      end
   end

   // RULE_04 input enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_en <= `GPIW_RST_ZERO;
      end else begin
         in_en <= next_in_en;
      end
   end

   // RULE_18 wake enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_en <= `GPIW_RST_ZERO;
      end else begin
         wake_en <= next_wake_en;
      end
   end

   // RULE_19 wake source enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pm_wake_src <= `GPIW_RST_PM_SRC;
      end else begin
         pm_wake_src <= next_pm_wake_src;
      end
   end

   // RULE_05 RULE_11 flag and wake status storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_flags <= `GPIW_RST_ZERO;
         wake_stat <= `GPIW_RST_ZERO;
      end else begin
         irq_flags <= next_irq_flags;
         wake_stat <= next_wake_stat;
      end
   end

   // RULE_03 RULE_10 RULE_13 RULE_14 RULE_17 shared requests
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_irq <= 1'b0;
         wake_irq <= 1'b0;
      end else begin
         port_irq <= |(next_irq_flags & next_irq_en);
         wake_irq <= |next_wake_stat;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_rise_seen(int i);
      !in_prev[i] && in_sync[i];
   endsequence

   sequence s_fall_seen(int i);
      in_prev[i] && !in_sync[i];
   endsequence

   sequence s_any_edge(int i);
      in_prev[i] != in_sync[i];
   endsequence

   sequence s_read_taken;
      take && !hwrite;
   endsequence

   sequence s_write_taken;
      take && hwrite;
   endsequence

   sequence s_read_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   gated_event_a: assert property ( // RULE_01
      (irq_flags & ~$past(irq_flags)) == ((irq_flags & ~$past(irq_flags)) & $past(armed)))
      else $error("flag set on disarmed pin");
   alt_func_a: assert property ( // RULE_02
      !cfg_sel0[0] && !irq_flags[0] |=> !irq_flags[0])
      else $error("flag set on pin in alternate function");
   input_gate_a: assert property ( // RULE_04
      !in_en[0] && !irq_flags[0] |=> !irq_flags[0])
      else $error("flag set with input disabled");
   level_high_a: assert property ( // RULE_07
      armed[0] && !trig_type[0] && trig_pol[0] && in_sync[0] |=> irq_flags[0])
      else $error("level high missed");
   level_low_a: assert property ( // RULE_07
      armed[0] && !trig_type[0] && !trig_pol[0] && !in_sync[0] |=> irq_flags[0])
      else $error("level low missed");
   rise_edge_a: assert property ( // RULE_08
      (armed[0] && trig_type[0] && !trig_pol[0]) ##0 s_rise_seen(0) |=> irq_flags[0])
      else $error("rising edge missed");
   fall_edge_a: assert property ( // RULE_08
      (armed[0] && trig_type[0] && trig_pol[0]) ##0 s_fall_seen(0) |=> irq_flags[0])
      else $error("falling edge missed");
   dual_edge_a: assert property ( // RULE_09
      (armed[0] && trig_type[0] && both_edges[0]) ##0 s_any_edge(0) |=> irq_flags[0])
      else $error("dual edge missed");
   flag_clear_a: assert property ( // RULE_05
      wr_fl_clr && hwdata[3] && !irq_set[3] |=> !irq_flags[3])
      else $error("flag not cleared");
   flag_hold_a: assert property ( // RULE_04
      irq_flags[0] && !(wr_fl_clr && hwdata[0]) |=> irq_flags[0])
      else $error("pending flag lost");
   multi_flag_a: assert property ( // RULE_11
      irq_set[3] && irq_set[7] |=> irq_flags[3] && irq_flags[7])
      else $error("simultaneous flags not both set");
   port_req_a: assert property ( // RULE_10
      |(irq_flags & irq_en) |-> port_irq || $rose(|(irq_flags & irq_en)))
      else $error("port request missing");
   port_quiet_a: assert property ( // RULE_03
      (irq_flags & irq_en) == 32'h00000000 |-> !port_irq)
      else $error("port request without enabled flag");
   wake_edge_a: assert property ( // RULE_16
      (wake_stat & ~$past(wake_stat) & ~$past(rise | fall)) == 32'h00000000)
      else $error("wake flag set without edge");
   wake_pin_en_a: assert property ( // RULE_18
      (wake_stat & ~$past(wake_stat) & ~$past(wake_en)) == 32'h00000000)
      else $error("wake flag set on disabled pin");
   wake_gate_a: assert property ( // RULE_19
      !pm_wake_src ##1 !pm_wake_src |-> (wake_stat & ~$past(wake_stat)) == 32'h00000000)
      else $error("wake without source enable");
   wake_mark_a: assert property ( // RULE_20
      wake_set[5] |=> wake_stat[5])
      else $error("waking pin not marked");
   wake_clear_a: assert property ( // RULE_21
      wr_wstat && hwdata == 32'hFFFFFFFF && wake_set == 32'h00000000
      |=> wake_stat == 32'h00000000 && !wake_irq)
      else $error("wake clear failed");
   wake_req_a: assert property ( // RULE_17
      wake_irq == (wake_stat != 32'h00000000))
      else $error("wake request mismatch");
   read_wait_a: assert property (
      s_read_taken |=> s_read_wait)
      else $error("read timing wrong");
   write_ready_a: assert property (
      s_write_taken |=> hreadyout)
      else $error("write wait state seen");
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench of the pin interrupt and wake block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0]  wa;
      logic [31:0] wd;
      logic [7:0]  ra;
      logic [31:0] ex;
   } gpiw_tb_row_t;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] pin_req = 32'h00000000;
   logic [31:0] pin_in;
   logic [31:0] pin_out;
   logic [31:0] pin_oe;
   logic        port_irq;
   logic        wake_irq;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cycles = 0;
   gpiw_tb_row_t rr [18] = '{
      '{8'h0C, 32'h0000FFFF, 8'h0C, 32'h0000FFFF}, '{8'h10, 32'h00FF0000, 8'h0C, 32'h00FFFFFF},
      '{8'h14, 32'h0000000F, 8'h0C, 32'h00FFFFF0}, '{8'h18, 32'h12345678, 8'h18, 32'h12345678},
      '{8'h20, 32'h00000078, 8'h18, 32'h12345600}, '{8'h08, 32'h0000000F, 8'h00, 32'hFFFFFFF0},
      '{8'h00, 32'hFFFFFFFF, 8'h00, 32'hFFFFFFFF}, '{8'h38, 32'h00000101, 8'h34, 32'h00000101},
      '{8'h3C, 32'h00000100, 8'h34, 32'h00000001}, '{8'h40, 32'hFFFFFFFF, 8'h40, 32'h00000000},
      '{8'hFC, 32'hFFFFFFFF, 8'hFC, 32'h00000000}, '{8'h84, 32'h00000001, 8'h84, 32'h00000001},
      '{8'h98, 32'hFFFFFFFF, 8'h98, 32'h00000001}, '{8'h24, 32'hFFFFFFFF, 8'h24, 32'h00000000},
      '{8'h28, 32'h0000000F, 8'h28, 32'h0000000F}, '{8'h2C, 32'h0000F000, 8'h2C, 32'h0000F000},
      '{8'h5C, 32'h00A00000, 8'h5C, 32'h00A00000}, '{8'h90, 32'h80000000, 8'h90, 32'h80000000}};
   // Bits: type, polarity, both edges, start level, end level, expected flag
   logic [5:0]  mr [10] = '{6'h17, 6'h10, 6'h01, 6'h06, 6'h23, 6'h24, 6'h35, 6'h32, 6'h2D, 6'h3B};

   gpiw_port dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .port_irq(port_irq), .wake_irq(wake_irq)
   );
   gpiw_pin_env pins_m (.pin_req(pin_req), .pin_lvl(pin_in));

   always #12.5 hclk = ~hclk;
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         close_out();
      end
   end

   function automatic logic [31:0] b0(input logic v);
      return {31'h00000000, v};
   endfunction
   task automatic close_out();
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Ready and read data are taken at the rising edge, before the slave updates
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, d, r);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h00000000, r);
      chk($sformatf("reg %h", a), e, r);
   endtask
   task automatic pins(input logic [31:0] v);
      pin_req <= v;
      repeat (5) @(posedge hclk);
   endtask
   task automatic rst_chk();
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rc(8'h00, 32'hFFFFFFFF);
      rc(8'h34, 32'h00000000);
      rc(8'h84, 32'h00000000);
      rc(8'h94, 32'h00000000);
      chk("port_irq", 32'h00000000, b0(port_irq));
      chk("wake_irq", 32'h00000000, b0(wake_irq));
      chk("hresp", 32'h00000000, b0(hresp));
   endtask

   initial begin
      rst_chk();
      foreach (rr[i]) begin
         wr(rr[i].wa, rr[i].wd);
         rc(rr[i].ra, rr[i].ex);
      end
      chk("pin_oe", 32'h00FFFFF0, pin_oe);
      chk("pin_out", 32'h12345600, pin_out);
      foreach (mr[i]) begin
         wr(8'h28, b0(mr[i][5]));
         wr(8'h2C, b0(mr[i][4]));
         wr(8'h5C, b0(mr[i][3]));
         pins(b0(mr[i][2]));
         wr(8'h48, 32'hFFFFFFFF);
         pins(b0(mr[i][1]));
         rc(8'h40, b0(mr[i][0]));
         chk("port_irq", b0(mr[i][0]), b0(port_irq));
      end
      wr(8'h5C, 32'h00000000);
      wr(8'h2C, 32'h00000000);
      pins(32'h00000000);
      wr(8'h48, 32'hFFFFFFFF);
      pins(32'h00000001);
      rc(8'h40, 32'h00000001);
      wr(8'h3C, 32'h00000001);
      repeat (2) @(posedge hclk);
      chk("port_irq", 32'h00000000, b0(port_irq));
      wr(8'h38, 32'h00000001);
      wr(8'h84, 32'h00000000);
      pins(32'h00000000);
      pins(32'h00000001);
      rc(8'h40, 32'h00000001);
      wr(8'h48, 32'h00000001);
      rc(8'h40, 32'h00000000);
      pins(32'h00000000);
      pins(32'h00000001);
      rc(8'h40, 32'h00000000);
      wr(8'h84, 32'h00000001);
      wr(8'h08, 32'h00000001);
      pins(32'h00000000);
      pins(32'h00000001);
      rc(8'h40, 32'h00000000);
      wr(8'h00, 32'hFFFFFFFF);
      wr(8'h84, 32'h00000088);
      wr(8'h28, 32'hFFFFFFFF);
      wr(8'h34, 32'h00000008);
      pins(32'h00000000);
      wr(8'h48, 32'hFFFFFFFF);
      pins(32'h00000088);
      rc(8'h40, 32'h00000088);
      chk("port_irq", 32'h00000001, b0(port_irq));
      wr(8'h48, 32'h00000088);
      rc(8'h40, 32'h00000000);
      chk("port_irq", 32'h00000000, b0(port_irq));
      wr(8'h94, 32'hFFFFFFFF);
      wr(8'h90, 32'h00000020);
      wr(8'h98, 32'h00000000);
      pins(32'h00000020);
      rc(8'h94, 32'h00000000);
      pins(32'h00000000);
      wr(8'h98, 32'h00000001);
      pins(32'h00000020);
      rc(8'h94, 32'h00000020);
      chk("wake_irq", 32'h00000001, b0(wake_irq));
      wr(8'h94, 32'hFFFFFFFF);
      rc(8'h94, 32'h00000000);
      chk("wake_irq", 32'h00000000, b0(wake_irq));
      pins(32'h00000060);
      rc(8'h94, 32'h00000000);
      rst_chk();
      close_out();
   end
endmodule
`default_nettype wire
